// [pkg/lpp_map.svh]
`ifndef LPP_MAP_SVH
`define LPP_MAP_SVH

// Command codes that steer the port's own write and read modes.
`define LPP_CMD_MEM_WRITE 8'h01
`define LPP_CMD_MEM_READ 8'h02
`define LPP_CMD_CURSOR_SET 8'h03
`define LPP_CMD_CURSOR_GET 8'h04

// Reset values.
`define LPP_CURSOR_RST 16'h0000
`define LPP_BYTE_RST 8'h00

// Width of the host data bus and of the cursor.
`define LPP_DATA_W 8
`define LPP_CURSOR_W 16

// Display memory size in bytes and its address width.
`define LPP_MEM_BYTES 32768
`define LPP_MEM_AW 15

// Status byte layout: mode code in the low bits, user flags above.
`define LPP_STAT_MODE_W 3
`define LPP_STAT_USER_W 5

`endif

// [pkg/lpp_pkg.sv]
`include "lpp_map.svh"

package lpp_pkg;

  // Host pins as seen at the connector, before synchronising.
  typedef struct packed {
    logic csN;
    logic rdEnable;
    logic wrDirection;
    logic cmdDataSelect;
    logic busStyleSelect;
    logic resetN;
    logic [`LPP_DATA_W-1:0] dataBusIn;
  } lpp_pins_type;

  // A byte handed on to the display engine.
  typedef struct packed {
    logic isCmd;
    logic [`LPP_DATA_W-1:0] value;
  } lpp_hostbyte_type;

  // What data writes and data reads currently mean.
  typedef enum logic [`LPP_STAT_MODE_W-1:0] {
    MODE_PARAM = 3'b000,
    MODE_MEMW = 3'b001,
    MODE_MEMR = 3'b010,
    MODE_CSRW_LO = 3'b011,
    MODE_CSRW_HI = 3'b100,
    MODE_CSRR = 3'b101
  } lpp_mode_type;

endpackage : lpp_pkg

// [logic/lpp_display_mem.sv]
`timescale 1ns/1ps
`include "lpp_map.svh"

module lpp_display_mem
  import lpp_pkg::*;
#(
  parameter int ADDR_W = `LPP_MEM_AW,
  parameter int DATA_W = `LPP_DATA_W
) (
  // Clock.
  input wire logic clk_sys,
  // Single access port.
  input wire logic writeEn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0] readData
);

  // Refuse sizes that would not fit the cursor.
  initial begin
    if (ADDR_W < 1 || ADDR_W > `LPP_CURSOR_W || DATA_W < 1) begin
      $error("lpp_display_mem: unsupported size");
    end
  end

  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];

  // Read data always come from a register, so reads see the old byte
  // in the cycle of a write to the same address.
  always_ff @(posedge clk_sys) begin
    if (writeEn) begin
      store[addr] <= writeData;
    end
    readData <= store[addr];
  end

endmodule : lpp_display_mem

// [logic/lpp_host_port.sv]
`timescale 1ns/1ps
`include "lpp_map.svh"

module lpp_host_port
  import lpp_pkg::*;
#(
  parameter int MEM_BYTES = `LPP_MEM_BYTES,
  parameter int MEM_AW = `LPP_MEM_AW
) (
  // Clock and synchronous reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Host connector pins, asynchronous to clk_sys.
  input wire lpp_pins_type hostPins,
  // Data bus drive back to the connector.
  output logic [`LPP_DATA_W-1:0] dataBusOut,
  output logic dataBusOe,
  // Bytes passed to the display engine.
  output lpp_hostbyte_type engineByte,
  output logic engineByteValid,
  // Flags from the display engine shown in the status byte.
  input wire logic [`LPP_STAT_USER_W-1:0] engineFlags,
  // Current cursor position.
  output logic [`LPP_CURSOR_W-1:0] cursor
);

  // Refuse a memory that is not the size its address width implies.
  initial begin
    if (MEM_BYTES != (1 << MEM_AW) || MEM_AW > `LPP_CURSOR_W) begin
      $error("lpp_host_port: memory size and address width disagree");
    end
  end

  // Cursor advance, used by both the write and the read path.
  function automatic logic [`LPP_CURSOR_W-1:0] nextCursor(
    input logic [`LPP_CURSOR_W-1:0] cur
  );
    nextCursor = cur + `LPP_CURSOR_W'(1);
  endfunction : nextCursor

  // Mode that a command byte selects.
  function automatic lpp_mode_type cmdMode(
    input logic [`LPP_DATA_W-1:0] code
  );
    case (code)
      `LPP_CMD_MEM_WRITE: cmdMode = MODE_MEMW;
      `LPP_CMD_MEM_READ: cmdMode = MODE_MEMR;
      `LPP_CMD_CURSOR_SET: cmdMode = MODE_CSRW_LO;
      `LPP_CMD_CURSOR_GET: cmdMode = MODE_CSRR;
      default: cmdMode = MODE_PARAM;
    endcase
  endfunction : cmdMode

  // Two-flop synchronisers on every pin; only stage two is read.
  lpp_pins_type pinsMeta_r;
  lpp_pins_type pinsSync_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pinsMeta_r <= '{csN: 1'b1, rdEnable: 1'b1, wrDirection: 1'b1,
                      resetN: 1'b1, default: '0};
      pinsSync_r <= '{csN: 1'b1, rdEnable: 1'b1, wrDirection: 1'b1,
                      resetN: 1'b1, default: '0};
    end else begin
      pinsMeta_r <= hostPins;
      pinsSync_r <= pinsMeta_r;
    end
  end

  // The reset pin joins the system reset after synchronising.
  logic portReset;
  assign portReset = rst | ~pinsSync_r.resetN;

  // Strobe decode per bus style; the split style uses both pins as
  // active-low strobes, the enable style uses direction and enable.
  logic enableStyle;
  logic readActive;
  logic writeActive;

  always_comb begin
    enableStyle = pinsSync_r.busStyleSelect;
    if (enableStyle) begin
      readActive = pinsSync_r.wrDirection & pinsSync_r.rdEnable;
      writeActive = ~pinsSync_r.wrDirection
                    & pinsSync_r.rdEnable;
    end else begin
      readActive = ~pinsSync_r.rdEnable;
      writeActive = ~pinsSync_r.wrDirection;
    end
    readActive = readActive & ~pinsSync_r.csN;
    writeActive = writeActive & ~pinsSync_r.csN;
  end

  // Port state.
  lpp_mode_type mode_r, mode_nxt;
  logic [`LPP_CURSOR_W-1:0] cursor_r, cursor_nxt;
  logic readPrev_r, readPrev_nxt;
  logic writePrev_r, writePrev_nxt;
  logic [`LPP_DATA_W-1:0] holdData_r, holdData_nxt;
  logic holdSelect_r, holdSelect_nxt;
  logic [`LPP_DATA_W-1:0] dataOut_r, dataOut_nxt;
  logic csrHighByte_r, csrHighByte_nxt;
  lpp_hostbyte_type engineByte_r, engineByte_nxt;
  logic engineValid_r, engineValid_nxt;
  logic memWrite;
  logic [`LPP_DATA_W-1:0] memReadData;

  // Display memory; it is always addressed by the cursor, so the byte
  // under the cursor is ready before the next read strobe is seen.
  lpp_display_mem #(
    .ADDR_W(MEM_AW),
    .DATA_W(`LPP_DATA_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .writeEn(memWrite),
    .addr(cursor_r[MEM_AW-1:0]),
    .writeData(holdData_r),
    .readData(memReadData)
  );

  // Next-state logic. A write is acted on when its strobe ends, using
  // the byte and select held while the strobe was still active, since
  // the host may change the bus in the same instant the strobe ends.
  always_comb begin
    mode_nxt = mode_r;
    cursor_nxt = cursor_r;
    readPrev_nxt = readActive;
    writePrev_nxt = writeActive;
    holdData_nxt = holdData_r;
    holdSelect_nxt = holdSelect_r;
    dataOut_nxt = dataOut_r;
    csrHighByte_nxt = csrHighByte_r;
    engineByte_nxt = engineByte_r;
    engineValid_nxt = 1'b0;
    memWrite = 1'b0;

    // Track bus byte and select while a strobe is active.
    if (writeActive || readActive) begin
      holdData_nxt = pinsSync_r.dataBusIn;
      holdSelect_nxt = pinsSync_r.cmdDataSelect;
    end

    // Write strobe ends: rising write strobe or falling enable.
    if (writePrev_r && !writeActive) begin
      if (holdSelect_r) begin
        mode_nxt = cmdMode(holdData_r);
        csrHighByte_nxt = 1'b0;
        engineByte_nxt = '{isCmd: 1'b1, value: holdData_r};
        engineValid_nxt = 1'b1;
      end else begin
        case (mode_r)
          MODE_MEMW: begin
            memWrite = 1'b1;
            cursor_nxt = nextCursor(cursor_r);
          end
          MODE_CSRW_LO: begin
            cursor_nxt = {cursor_r[`LPP_CURSOR_W-1:`LPP_DATA_W],
                          holdData_r};
            mode_nxt = MODE_CSRW_HI;
          end
          MODE_CSRW_HI: begin
            cursor_nxt = {holdData_r, cursor_r[`LPP_DATA_W-1:0]};
            mode_nxt = MODE_PARAM;
          end
          default: begin
            engineByte_nxt = '{isCmd: 1'b0, value: holdData_r};
            engineValid_nxt = 1'b1;
          end
        endcase
      end
    end

    // Read strobe begins: load the byte the host will see.
    if (readActive && !readPrev_r) begin
      if (!pinsSync_r.cmdDataSelect) begin
        dataOut_nxt = {engineFlags, mode_r};
      end else if (mode_r == MODE_CSRR) begin
        dataOut_nxt = csrHighByte_r
                      ? cursor_r[`LPP_CURSOR_W-1:`LPP_DATA_W]
                      : cursor_r[`LPP_DATA_W-1:0];
      end else begin
        dataOut_nxt = memReadData;
      end
    end

    // Read strobe ends: step past the byte just read.
    if (readPrev_r && !readActive && holdSelect_r) begin
      if (mode_r == MODE_CSRR) begin
        csrHighByte_nxt = ~csrHighByte_r;
      end else if (mode_r == MODE_MEMR) begin
        cursor_nxt = nextCursor(cursor_r);
      end
    end
  end

  // State registers.
  always_ff @(posedge clk_sys) begin
    if (portReset) begin
      mode_r <= MODE_PARAM;
      cursor_r <= `LPP_CURSOR_RST;
      readPrev_r <= 1'b0;
      writePrev_r <= 1'b0;
      holdData_r <= `LPP_BYTE_RST;
      holdSelect_r <= 1'b0;
      dataOut_r <= `LPP_BYTE_RST;
      csrHighByte_r <= 1'b0;
      engineByte_r <= '{isCmd: 1'b0, value: `LPP_BYTE_RST};
      engineValid_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      cursor_r <= cursor_nxt;
      readPrev_r <= readPrev_nxt;
      writePrev_r <= writePrev_nxt;
      holdData_r <= holdData_nxt;
      holdSelect_r <= holdSelect_nxt;
      dataOut_r <= dataOut_nxt;
      csrHighByte_r <= csrHighByte_nxt;
      engineByte_r <= engineByte_nxt;
      engineValid_r <= engineValid_nxt;
    end
  end

  // Bus drive. The enable waits one cycle for the data register to be
  // loaded, so the host never sees a stale byte; the cost is a short
  // extra delay that the host's access time must cover.
  assign dataBusOe = readActive & readPrev_r & ~portReset;
  assign dataBusOut = dataOut_r;

  // Engine side.
  assign engineByte = engineByte_r;
  assign engineByteValid = engineValid_r;
  assign cursor = cursor_r;

endmodule : lpp_host_port

// [sim/lpp_host_port_properties.sv]
`timescale 1ns/1ps

module lpp_host_port_checker
  import lpp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst,
  // Watched ports.
  input wire lpp_pins_type hostPins,
  input wire logic [7:0] dataBusOut,
  input wire logic dataBusOe,
  input wire lpp_hostbyte_type engineByte,
  input wire logic engineByteValid,
  input wire logic [4:0] engineFlags,
  input wire logic [15:0] cursor
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic readPin;
  // A read as the pins show it in either style.
  assign readPin = !hostPins.csN && hostPins.resetN &&
    (hostPins.busStyleSelect ? hostPins.rdEnable && hostPins.wrDirection
    : !hostPins.rdEnable);
  sequence splitRdS;
    !hostPins.busStyleSelect && readPin;
  endsequence
  sequence enRdS;
    hostPins.busStyleSelect && readPin;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !dataBusOe && !engineByteValid && cursor == 16'h0000)
    else $error("port not quiet after reset");
  a_pin_reset: assert property ((!hostPins.resetN)[*5] |=>
    !dataBusOe && !engineByteValid && cursor == 16'h0000)
    else $error("reset pin ignored");
  a_cs_gate: assert property (hostPins.csN[*6] |->
    !dataBusOe && !engineByteValid) else $error("acted while deselected");
  a_split_read: assert property (splitRdS[*5] |-> dataBusOe)
    else $error("split read not driven");
  a_enable_read: assert property (enRdS[*5] |-> dataBusOe)
    else $error("enable read not driven");
  a_bus_release: assert property ((!readPin)[*4] |-> !dataBusOe)
    else $error("bus driven without a read");
  a_status_byte: assert property (
    (readPin && !hostPins.cmdDataSelect)[*6] |->
    dataBusOut[7:3] == engineFlags) else $error("bad status flags");
  a_pulse_single: assert property (
    engineByteValid |=> !engineByteValid) else $error("pulse too long");
  a_cmd_flag: assert property (engineByteValid |->
    engineByte.isCmd == $past(hostPins.cmdDataSelect, 4))
    else $error("command flag wrong");
endmodule : lpp_host_port_checker

bind lpp_host_port lpp_host_port_checker chk (.clk_sys(clk_sys), .rst(rst),
  .hostPins(hostPins), .dataBusOut(dataBusOut), .dataBusOe(dataBusOe),
  .engineByte(engineByte), .engineByteValid(engineByteValid),
  .engineFlags(engineFlags), .cursor(cursor));

// [sim/lpp_host_model.sv]
`timescale 1ns/1ps

module lpp_host_model
  import lpp_pkg::*;
(
  // Clock.
  input wire logic clk_sys,
  // Pins and the port's drive back.
  output lpp_pins_type hostPins,
  input wire logic [7:0] dataBusOut,
  input wire logic dataBusOe
);
  logic [7:0] hostData = 8'h00;
  logic [7:0] busLast = 8'h00;
  logic [7:0] busLevel;
  logic csN = 1'b1, rdEn = 1'b1, wrDir = 1'b1, sel = 1'b0;
  logic style = 1'b0, resetN = 1'b1, hostDrive = 1'b0;
  // A released bus toggles, so a stale byte never passes for read data.
  assign busLevel = dataBusOe ? dataBusOut : hostDrive ? hostData : ~busLast;
  always @(posedge clk_sys) busLast <= busLevel;
  assign hostPins = '{csN, rdEn, wrDir, sel, style, resetN, busLevel};
  // One access; select and direction stay put through the strobe.
  task automatic acc(input logic rd, input logic cmd, input logic cs,
    input logic [7:0] din, output logic [7:0] dout);
    @(posedge clk_sys);
    csN <= !cs;
    sel <= cmd;
    hostData <= din;
    hostDrive <= !rd;
    if (style) wrDir <= rd;
    @(posedge clk_sys);
    if (style) rdEn <= 1'b1;
    else if (rd) rdEn <= 1'b0;
    else wrDir <= 1'b0;
    repeat (6) @(posedge clk_sys);
    dout = busLevel;
    rdEn <= !style;
    if (!style) wrDir <= 1'b1;
    @(posedge clk_sys);
    csN <= 1'b1;
    hostDrive <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask : acc
  // Hold the reset pin low well past the synchroniser.
  task automatic pinReset();
    @(posedge clk_sys);
    resetN <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetN <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : pinReset
  task automatic setStyle(input logic s);
    @(posedge clk_sys);
    style <= s;
    rdEn <= !s;
    wrDir <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : setStyle
endmodule : lpp_host_model

// [sim/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  import lpp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [4:0] engineFlags = 5'h15;
  lpp_pins_type hostPins;
  lpp_hostbyte_type engineByte, lastByte;
  logic [7:0] dataBusOut, rdByte;
  logic [15:0] cursor, n;
  logic [15:0] nValid = 16'h0000;
  logic dataBusOe, engineByteValid;
  int n_fail = 0;
  int checks = 0;
  // Half period of the 250 MHz clock.
  always #2 clk_sys = ~clk_sys;
  lpp_host_port dut (.clk_sys(clk_sys), .rst(rst), .hostPins(hostPins),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe), .engineByte(engineByte),
    .engineByteValid(engineByteValid), .engineFlags(engineFlags),
    .cursor(cursor));
  lpp_host_model host (.clk_sys(clk_sys), .hostPins(hostPins),
    .dataBusOut(dataBusOut), .dataBusOe(dataBusOe));
  // The pulse lasts one cycle, so keep what it carried.
  always @(posedge clk_sys) begin
    if (engineByteValid === 1'b1) begin
      lastByte <= engineByte;
      nValid <= nValid + 16'h0001;
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic w(input logic cmd, input logic [7:0] b);
    host.acc(1'h0, cmd, 1'h1, b, rdByte);
  endtask : w
  task automatic r(input logic cmd, input logic [7:0] exp);
    host.acc(1'h1, cmd, 1'h1, 8'h00, rdByte);
    cmp({8'h00, rdByte}, {8'h00, exp});
  endtask : r
  task automatic setCur(input logic [7:0] hi, input logic [7:0] lo);
    w(1'h1, 8'h03);
    w(1'h0, lo);
    w(1'h0, hi);
  endtask : setCur
  task automatic t_split();
    setCur(8'h12, 8'h34);
    cmp(cursor, 16'h1234);
    w(1'h1, 8'h01);
    w(1'h0, 8'hA5);
    w(1'h0, 8'h5A);
    cmp(cursor, 16'h1236);
    setCur(8'h12, 8'h34);
    w(1'h1, 8'h02);
    r(1'h1, 8'hA5);
    r(1'h1, 8'h5A);
    r(1'h0, 8'hAA);
    $display("test split done");
  endtask : t_split
  // The top cursor address folds onto the last byte of memory.
  task automatic t_bound();
    setCur(8'h7F, 8'hFF);
    w(1'h1, 8'h01);
    w(1'h0, 8'h3C);
    setCur(8'hFF, 8'hFF);
    w(1'h1, 8'h02);
    r(1'h1, 8'h3C);
    $display("test bound done");
  endtask : t_bound
  task automatic t_enable();
    host.setStyle(1'h1);
    w(1'h1, 8'h47);
    cmp({7'h00, lastByte}, 16'h0147);
    w(1'h0, 8'h99);
    cmp({7'h00, lastByte}, 16'h0099);
    r(1'h0, 8'hA8);
    host.setStyle(1'h0);
    $display("test enable done");
  endtask : t_enable
  task automatic t_csgate();
    n = nValid;
    host.acc(1'h0, 1'h0, 1'h0, 8'h11, rdByte);
    host.acc(1'h1, 1'h0, 1'h0, 8'h00, rdByte);
    cmp(nValid, n);
    w(1'h0, 8'h11);
    cmp(nValid, n + 16'h0001);
    $display("test csgate done");
  endtask : t_csgate
  // Cursor readback first, so the reset pin has a cursor and a mode to undo.
  task automatic t_pinreset();
    setCur(8'h56, 8'h78);
    w(1'h1, 8'h04);
    r(1'h1, 8'h78);
    r(1'h1, 8'h56);
    r(1'h0, 8'hAD);
    host.pinReset();
    cmp(cursor, 16'h0000);
    r(1'h0, 8'hA8);
    @(posedge clk_sys);
    engineFlags <= 5'h0A;
    r(1'h0, 8'h50);
    $display("test pinreset done");
  endtask : t_pinreset
  task automatic results();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    cmp({15'h0, dataBusOe}, 16'h0000);
    t_split();
    t_bound();
    t_enable();
    t_csgate();
    t_pinreset();
    results();
  end
endmodule : tb_top
